// ### verilog/reg_ram_transfer_exec.sv
// Purpose: Executes register, RAM-address and RAM-to-register transfers.
// Assumes: One instruction per mclk cycle when exec is high; memory read data
//          is combinational for the current data pointer.
// Notes: Skips asked by this block go out as a one-cycle skip_next pulse.

// Overview of operation
// - Bank register into accumulator low bits, upper cleared.
// - Stack pointer into accumulator low bits, bit3 cleared.
// - Immediate load of row and column registers.
// - Immediate load of two-bit bank register.
// - Increment column register, wrapping.
// - Decrement column register, wrapping.
// - Memory into accumulator, row XOR immediate.
// - Swap accumulator and memory, row XOR immediate.
// - Swap, row XOR, then decrement column.
// - Swap, row XOR, then increment column.
// - Accumulator into memory, row XOR immediate.
// - Accumulator to second, accumulator unchanged.
// - Column to accumulator and back.
// - Column loaded from accumulator.
// - Pair gets second high, accumulator low.
// - Pair splits into second and accumulator.
// - Accumulator low three bits into index register.
// - Skip next when incremented column is zero.
// - Skip next when decremented column is fifteen.
// - Consecutive row-column loads: only first executes.
module reg_ram_transfer_exec (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [9:0] instr,
  input  wire logic       exec,
  input  wire logic       skipped,
  input  wire logic [2:0] stack_pointer,
  input  wire logic [3:0] mem_rdata,
  output logic      [3:0] acc,
  output logic      [3:0] second,
  output logic      [3:0] row,
  output logic      [3:0] column,
  output logic      [1:0] bank,
  output logic      [2:0] index,
  output logic      [7:0] pair,
  output logic      [3:0] mem_wdata,
  output logic            mem_we,
  output logic            skip_next
);
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] second;
    logic [3:0] row;
    logic [3:0] column;
    logic [1:0] bank;
    logic [2:0] index;
    logic [7:0] pair;
    logic [3:0] wdata;
    logic       we;
    logic       skip;
    logic       last_row_col;
  } state_s;

  state_s     r;
  state_s     nxt;
  logic       run;
  logic       run_gated;
  logic [3:0] imm;

  xfer_dec_if d ();

  // An instruction already flagged as skipped changes no register here, but it clears the row-column chain flag.
  assign run = exec && !skipped;
  // A row-column load directly after another one is treated as skipped.
  assign run_gated = run
                     && !(r.last_row_col && instr[9:8] == xfer_pkg::OPH_LOAD_ROW_COL_IMM);
  assign imm = instr[3:0];

  xfer_decoder u_dec (
    .instr (instr),
    .exec  (run_gated),
    .d     (d)
  );

  always_comb
  begin
    nxt = r;
    nxt.we = 1'b0;
    nxt.skip = 1'b0;
    // The chain flag follows every executed or suppressed word in the run.
    if (exec)
      nxt.last_row_col = instr[9:8] == xfer_pkg::OPH_LOAD_ROW_COL_IMM && !skipped;
    if (exec && !skipped && r.last_row_col && instr[9:8] == xfer_pkg::OPH_LOAD_ROW_COL_IMM)
      nxt.last_row_col = 1'b1;
    // All updates of one word land at the same edge.
    if (d.acc_from_second)
      nxt.acc = r.second;
    if (d.second_from_acc)
      nxt.second = r.acc;
    if (d.acc_from_column)
      nxt.acc = r.column;
    if (d.pair_from_second_acc)
      nxt.pair = {r.second, r.acc};
    if (d.second_acc_from_pair)
    begin
      nxt.second = r.pair[7:4];
      nxt.acc = r.pair[3:0];
    end
    if (d.index_from_acc)
      nxt.index = r.acc[2:0];
    if (d.acc_from_index)
      nxt.acc = {1'b0, r.index};
    if (d.acc_from_bank)
      nxt.acc = {2'b00, r.bank};
    if (d.acc_from_row)
      nxt.acc = r.row;
    if (d.acc_from_stack_ptr)
      nxt.acc = {1'b0, stack_pointer};
    if (d.load_row_col_imm)
      nxt.row = instr[7:4];
    if (d.load_bank_imm)
      nxt.bank = instr[1:0];
    if (d.load_acc_from_mem || d.swap_acc_mem)
      nxt.acc = mem_rdata;
    if (d.swap_acc_mem || d.store_acc_to_mem)
    begin
      nxt.wdata = r.acc;
      nxt.we = 1'b1;
    end
    if (d.row_xor)
      nxt.row = r.row ^ imm;
    case (d.col_op)
      xfer_pkg::COL_IMM:
        nxt.column = instr[3:0];
      xfer_pkg::COL_ACC:
        nxt.column = r.acc;
      xfer_pkg::COL_INC:
      begin
        nxt.column = r.column + 4'h1;
        nxt.skip = (r.column + 4'h1) == xfer_pkg::NIB_RESET;
      end
      xfer_pkg::COL_DEC:
      begin
        nxt.column = r.column - 4'h1;
        nxt.skip = (r.column - 4'h1) == xfer_pkg::NIB_ALL_ONES;
      end
      default:
        nxt.column = r.column;
    endcase
    if (!rst_n)
    begin
      nxt.acc = xfer_pkg::NIB_RESET;
      nxt.second = xfer_pkg::NIB_RESET;
      nxt.row = xfer_pkg::NIB_RESET;
      nxt.column = xfer_pkg::NIB_RESET;
      nxt.bank = xfer_pkg::BANK_RESET;
      nxt.index = xfer_pkg::IDX_RESET;
      nxt.pair = xfer_pkg::PAIR_RESET;
      nxt.wdata = xfer_pkg::NIB_RESET;
      nxt.we = 1'b0;
      nxt.skip = 1'b0;
      nxt.last_row_col = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    r <= nxt;
  end

  assign acc = r.acc;
  assign second = r.second;
  assign row = r.row;
  assign column = r.column;
  assign bank = r.bank;
  assign index = r.index;
  assign pair = r.pair;
  assign mem_wdata = r.wdata;
  assign mem_we = r.we;
  assign skip_next = r.skip;

  logic live;
  assign live = rst_n && exec && !skipped;

  bank_to_acc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == 10'h053 |=> acc == {2'b00, $past(bank)})
    else $error("bank copy into accumulator wrong");
  stack_to_acc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == 10'h050 |=> acc == {1'b0, $past(stack_pointer)})
    else $error("stack pointer copy into accumulator wrong");
  bank_imm_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:2] == 8'h12 |=> bank == $past(instr[1:0]))
    else $error("bank immediate load wrong");
  inc_skip_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == 10'h013 |=> column == $past(column) + 4'h1
      && skip_next == (column == 4'h0))
    else $error("column increment or its skip wrong");
  dec_skip_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == 10'h017 |=> column == $past(column) - 4'h1
      && skip_next == (column == 4'hf))
    else $error("column decrement or its skip wrong");
  mem_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:4] == 6'h2c |=> acc == $past(mem_rdata)
      && row == ($past(row) ^ $past(instr[3:0])) && !mem_we)
    else $error("memory load or row xor wrong");
  swap_mem_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:4] == 6'h2d |=> acc == $past(mem_rdata)
      && mem_we && mem_wdata == $past(acc))
    else $error("accumulator memory swap wrong");
  store_mem_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:4] == 6'h2b |=> mem_we && mem_wdata == $past(acc)
      && acc == $past(acc))
    else $error("accumulator store wrong");
  pair_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == 10'h01a |=> pair == {$past(second), $past(acc)})
    else $error("pair load wrong");
  pair_unload_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == 10'h02a |=> {second, acc} == $past(pair))
    else $error("pair unload wrong");
  index_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == 10'h029 |=> index == $past(acc[2:0]))
    else $error("index load wrong");
  row_col_chain_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:8] == 2'h3 ##1 live && instr[9:8] == 2'h3
      |=> row == $past(row, 1) && column == $past(column, 1))
    else $error("chained row column load executed");

  // Word classes and a register snapshot used by the checks below.
  logic        mem_word;
  logic        step_word;
  logic [28:0] regs_now;
  assign mem_word = live && (instr[9:4] == xfer_pkg::OPH_STORE_ACC_MEM
                    || instr[9:4] == xfer_pkg::OPH_SWAP_ACC_MEM
                    || instr[9:4] == xfer_pkg::OPH_SWAP_DEC
                    || instr[9:4] == xfer_pkg::OPH_SWAP_INC);
  assign step_word = live && (instr == xfer_pkg::OP_INC_COLUMN
                     || instr == xfer_pkg::OP_DEC_COLUMN
                     || instr[9:4] == xfer_pkg::OPH_SWAP_DEC
                     || instr[9:4] == xfer_pkg::OPH_SWAP_INC);
  assign regs_now = {acc, second, row, column, bank, index, pair};

  // Immediate loads and the memory words that also move the row or column.
  row_col_imm_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:8] == xfer_pkg::OPH_LOAD_ROW_COL_IMM && !r.last_row_col
      |=> row == $past(instr[7:4]) && column == $past(instr[3:0]))
    else $error("row column immediate load wrong");

  row_col_run_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:8] == xfer_pkg::OPH_LOAD_ROW_COL_IMM
      ##1 live && instr[9:8] == xfer_pkg::OPH_LOAD_ROW_COL_IMM
      ##1 live && instr[9:8] == xfer_pkg::OPH_LOAD_ROW_COL_IMM
      |=> row == $past(row, 2) && column == $past(column, 2))
    else $error("later row column load in a run executed");

  swap_row_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:4] == xfer_pkg::OPH_SWAP_ACC_MEM
      |=> row == ($past(row) ^ $past(instr[3:0])) && !skip_next)
    else $error("row xor after swap wrong");

  store_row_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:4] == xfer_pkg::OPH_STORE_ACC_MEM
      |=> row == ($past(row) ^ $past(instr[3:0])))
    else $error("row xor after store wrong");

  swap_dec_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:4] == xfer_pkg::OPH_SWAP_DEC
      |=> acc == $past(mem_rdata) && mem_we && mem_wdata == $past(acc)
      && row == ($past(row) ^ $past(instr[3:0])) && column == $past(column) - 4'h1)
    else $error("swap with column decrement wrong");

  swap_dec_skip_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:4] == xfer_pkg::OPH_SWAP_DEC
      |=> skip_next == (column == 4'hf))
    else $error("skip after swap with decrement wrong");

  swap_inc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:4] == xfer_pkg::OPH_SWAP_INC
      |=> acc == $past(mem_rdata) && mem_we && mem_wdata == $past(acc)
      && row == ($past(row) ^ $past(instr[3:0])) && column == $past(column) + 4'h1)
    else $error("swap with column increment wrong");

  swap_inc_skip_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr[9:4] == xfer_pkg::OPH_SWAP_INC
      |=> skip_next == (column == 4'h0))
    else $error("skip after swap with increment wrong");

  // Plain register copies.
  second_to_acc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == xfer_pkg::OP_ACC_FROM_SECOND
      |=> acc == $past(second) && second == $past(second))
    else $error("second copy into accumulator wrong");

  acc_to_second_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == xfer_pkg::OP_SECOND_FROM_ACC
      |=> second == $past(acc) && acc == $past(acc))
    else $error("accumulator copy into second wrong");

  column_to_acc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == xfer_pkg::OP_ACC_FROM_COLUMN
      |=> acc == $past(column) && column == $past(column))
    else $error("column copy into accumulator wrong");

  acc_to_column_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == xfer_pkg::OP_COLUMN_FROM_ACC
      |=> column == $past(acc) && acc == $past(acc))
    else $error("accumulator copy into column wrong");

  row_to_acc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == xfer_pkg::OP_ACC_FROM_ROW
      |=> acc == $past(row))
    else $error("row copy into accumulator wrong");

  index_to_acc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    live && instr == xfer_pkg::OP_ACC_FROM_INDEX
      |=> acc == {1'b0, $past(index)})
    else $error("index copy into accumulator wrong");

  // Words that must leave a register alone, the write and skip sources, and reset clearing.
  skipped_word_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && exec && skipped
      |=> regs_now == $past(regs_now) && !mem_we && !skip_next)
    else $error("skipped word changed state");

  idle_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && !exec
      |=> regs_now == $past(regs_now) && !mem_we && !skip_next)
    else $error("idle cycle changed state");

  we_source_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && !mem_word
      |=> !mem_we && mem_wdata == $past(mem_wdata))
    else $error("memory write without a store or swap");

  skip_source_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && !step_word |=> !skip_next)
    else $error("skip request without a column step");

  reset_clear_a: assert property (@(posedge mclk)
    !rst_n
      |=> regs_now == 29'h0000_0000 && mem_wdata == 4'h0 && !mem_we && !skip_next)
    else $error("reset left a register set");

  pair_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && !(live && instr == xfer_pkg::OP_PAIR_FROM_SEC_ACC)
      |=> pair == $past(pair))
    else $error("pair changed without a pair load");

  index_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && !(live && instr == xfer_pkg::OP_INDEX_FROM_ACC)
      |=> index == $past(index))
    else $error("index changed without an index load");

  bank_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && !(live && instr[9:2] == xfer_pkg::OPH_LOAD_BANK_IMM)
      |=> bank == $past(bank))
    else $error("bank changed without a bank load");

  second_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && !(live && (instr == xfer_pkg::OP_SECOND_FROM_ACC
      || instr == xfer_pkg::OP_SEC_ACC_FROM_PAIR))
      |=> second == $past(second))
    else $error("second changed without a load");
endmodule

// ### verilog/xfer_pkg.sv
// Purpose: Constants and shared types for the transfer instruction executor.
// Assumes: 10-bit instruction words, 4-bit nibbles, one instruction per cycle.
// Notes: Opcodes are full 10-bit words or upper-bit patterns with an immediate.
package xfer_pkg;
  localparam logic [9:0] OP_ACC_FROM_SECOND   = 10'h01e;
  localparam logic [9:0] OP_SECOND_FROM_ACC   = 10'h00e;
  localparam logic [9:0] OP_ACC_FROM_COLUMN   = 10'h01f;
  localparam logic [9:0] OP_COLUMN_FROM_ACC   = 10'h00c;
  localparam logic [9:0] OP_PAIR_FROM_SEC_ACC = 10'h01a;
  localparam logic [9:0] OP_SEC_ACC_FROM_PAIR = 10'h02a;
  localparam logic [9:0] OP_INDEX_FROM_ACC    = 10'h029;
  localparam logic [9:0] OP_ACC_FROM_INDEX    = 10'h051;
  localparam logic [9:0] OP_ACC_FROM_BANK     = 10'h053;
  localparam logic [9:0] OP_ACC_FROM_ROW      = 10'h052;
  localparam logic [9:0] OP_ACC_FROM_STACK    = 10'h050;
  localparam logic [9:0] OP_INC_COLUMN        = 10'h013;
  localparam logic [9:0] OP_DEC_COLUMN        = 10'h017;
  // Upper bits of immediate forms, then the reset and all-ones values.
  localparam logic [7:0] OPH_LOAD_BANK_IMM    = 8'h12;
  localparam logic [1:0] OPH_LOAD_ROW_COL_IMM = 2'h3;
  localparam logic [5:0] OPH_LOAD_ACC_MEM     = 6'h2c;
  localparam logic [5:0] OPH_SWAP_ACC_MEM     = 6'h2d;
  localparam logic [5:0] OPH_SWAP_DEC         = 6'h2f;
  localparam logic [5:0] OPH_SWAP_INC         = 6'h2e;
  localparam logic [5:0] OPH_STORE_ACC_MEM    = 6'h2b;
  localparam logic [3:0] NIB_RESET            = 4'h0;
  localparam logic [3:0] NIB_ALL_ONES         = 4'hf;
  localparam logic [7:0] PAIR_RESET           = 8'h00;
  localparam logic [2:0] IDX_RESET            = 3'h0;
  localparam logic [1:0] BANK_RESET           = 2'h0;

  typedef enum logic [3:0] {
    COL_HOLD = 4'b0000,
    COL_INC  = 4'b0001,
    COL_DEC  = 4'b0010,
    COL_ACC  = 4'b0011,
    COL_IMM  = 4'b0100
  } col_op_e;
endpackage

// ### verilog/xfer_dec_if.sv
// Purpose: Carries decoded control from the decoder to the executor.
// Assumes: Purely combinational content, one instruction per cycle.
// Notes: The decoder drives everything, the executor only reads.
interface xfer_dec_if;
  logic                  acc_from_second;
  logic                  second_from_acc;
  logic                  acc_from_column;
  logic                  pair_from_second_acc;
  logic                  second_acc_from_pair;
  logic                  index_from_acc;
  logic                  acc_from_index;
  logic                  acc_from_bank;
  logic                  acc_from_row;
  logic                  acc_from_stack_ptr;
  logic                  load_row_col_imm;
  logic                  load_bank_imm;
  logic                  load_acc_from_mem;
  logic                  swap_acc_mem;
  logic                  store_acc_to_mem;
  logic                  row_xor;
  xfer_pkg::col_op_e     col_op;
  modport dec (output acc_from_second, second_from_acc, acc_from_column,
               pair_from_second_acc, second_acc_from_pair, index_from_acc,
               acc_from_index, acc_from_bank, acc_from_row, acc_from_stack_ptr,
               load_row_col_imm, load_bank_imm, load_acc_from_mem, swap_acc_mem,
               store_acc_to_mem, row_xor, col_op);
  modport exe (input acc_from_second, second_from_acc, acc_from_column,
               pair_from_second_acc, second_acc_from_pair, index_from_acc,
               acc_from_index, acc_from_bank, acc_from_row, acc_from_stack_ptr,
               load_row_col_imm, load_bank_imm, load_acc_from_mem, swap_acc_mem,
               store_acc_to_mem, row_xor, col_op);
endinterface

// ### verilog/xfer_decoder.sv
// Purpose: Decodes one 10-bit instruction word into transfer controls.
// Assumes: The word is valid only when exec is high.
// Notes: Unknown words decode to no operation.
module xfer_decoder (
  input  wire logic [9:0] instr,
  input  wire logic       exec,
  xfer_dec_if.dec         d
);
  always_comb
  begin
    d.acc_from_second      = exec && instr == xfer_pkg::OP_ACC_FROM_SECOND;
    d.second_from_acc      = exec && instr == xfer_pkg::OP_SECOND_FROM_ACC;
    d.acc_from_column      = exec && instr == xfer_pkg::OP_ACC_FROM_COLUMN;
    d.pair_from_second_acc = exec && instr == xfer_pkg::OP_PAIR_FROM_SEC_ACC;
    d.second_acc_from_pair = exec && instr == xfer_pkg::OP_SEC_ACC_FROM_PAIR;
    d.index_from_acc       = exec && instr == xfer_pkg::OP_INDEX_FROM_ACC;
    d.acc_from_index       = exec && instr == xfer_pkg::OP_ACC_FROM_INDEX;
    d.acc_from_bank        = exec && instr == xfer_pkg::OP_ACC_FROM_BANK;
    d.acc_from_row         = exec && instr == xfer_pkg::OP_ACC_FROM_ROW;
    d.acc_from_stack_ptr   = exec && instr == xfer_pkg::OP_ACC_FROM_STACK;
    d.load_row_col_imm     = exec && instr[9:8] == xfer_pkg::OPH_LOAD_ROW_COL_IMM;
    d.load_bank_imm        = exec && instr[9:2] == xfer_pkg::OPH_LOAD_BANK_IMM;
    d.load_acc_from_mem    = exec && instr[9:4] == xfer_pkg::OPH_LOAD_ACC_MEM;
    d.store_acc_to_mem     = exec && instr[9:4] == xfer_pkg::OPH_STORE_ACC_MEM;
    d.swap_acc_mem         = exec && (instr[9:4] == xfer_pkg::OPH_SWAP_ACC_MEM
                             || instr[9:4] == xfer_pkg::OPH_SWAP_DEC
                             || instr[9:4] == xfer_pkg::OPH_SWAP_INC);
    d.row_xor              = d.load_acc_from_mem || d.store_acc_to_mem || d.swap_acc_mem;
    d.col_op               = xfer_pkg::COL_HOLD;
    if (d.load_row_col_imm)
      d.col_op = xfer_pkg::COL_IMM;
    else if (exec && instr == xfer_pkg::OP_COLUMN_FROM_ACC)
      d.col_op = xfer_pkg::COL_ACC;
    else if (exec && (instr == xfer_pkg::OP_INC_COLUMN
             || instr[9:4] == xfer_pkg::OPH_SWAP_INC))
      d.col_op = xfer_pkg::COL_INC;
    else if (exec && (instr == xfer_pkg::OP_DEC_COLUMN
             || instr[9:4] == xfer_pkg::OPH_SWAP_DEC))
      d.col_op = xfer_pkg::COL_DEC;
  end
endmodule

// ### tb/reg_ram_transfer_exec_tb.sv
// Purpose: Self-checking bench for the transfer instruction executor.
// Assumes: One word per cycle; inputs change on the falling edge of mclk.
// Notes: Each table row is taken at one rising edge and checked at the next falling edge.
`define CHECK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module reg_ram_transfer_exec_tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [9:0]  instr;
    logic [1:0]  es;
    logic [2:0]  stk;
    logic [3:0]  md;
    logic [15:0] abxy;
    logic [4:0]  zd;
    logic [7:0]  e;
    logic [1:0]  ws;
    logic [3:0]  wd;
  } row_s;

  logic       mclk;
  logic       rst_n;
  logic [9:0] instr;
  logic       exec;
  logic       skipped;
  logic [2:0] stack_pointer;
  logic [3:0] mem_rdata;
  logic [3:0] acc;
  logic [3:0] second;
  logic [3:0] row;
  logic [3:0] column;
  logic [1:0] bank;
  logic [2:0] index;
  logic [7:0] pair;
  logic [3:0] mem_wdata;
  logic       mem_we;
  logic       skip_next;
  int         failures;
  int         tests_run;
  int         cycles;
  row_s       rows [30];

  reg_ram_transfer_exec dut (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .instr         (instr),
    .exec          (exec),
    .skipped       (skipped),
    .stack_pointer (stack_pointer),
    .mem_rdata     (mem_rdata),
    .acc           (acc),
    .second        (second),
    .row           (row),
    .column        (column),
    .bank          (bank),
    .index         (index),
    .pair          (pair),
    .mem_wdata     (mem_wdata),
    .mem_we        (mem_we),
    .skip_next     (skip_next)
  );

  always #5 mclk = ~mclk;

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hung run is cut short well past the expected 37 cycles.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic check_cleared();
    `CHECK({acc, second, row, column, bank, index, pair}, 29'h0000_0000)
    `CHECK({mem_we, skip_next, mem_wdata}, 6'h00)
  endtask

  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    instr = 10'h000;
    exec = 1'b0;
    skipped = 1'b0;
    stack_pointer = 3'h0;
    mem_rdata = 4'h0;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    rows = '{
      '{10'h35a, 2'h2, 3'h0, 4'h0, 16'h005a, 5'h00, 8'h00, 2'h0, 4'h0},
      '{10'h3ff, 2'h2, 3'h0, 4'h0, 16'h005a, 5'h00, 8'h00, 2'h0, 4'h0},
      '{10'h312, 2'h2, 3'h0, 4'h0, 16'h005a, 5'h00, 8'h00, 2'h0, 4'h0},
      '{10'h04a, 2'h2, 3'h0, 4'h0, 16'h005a, 5'h10, 8'h00, 2'h0, 4'h0},
      '{10'h053, 2'h2, 3'h0, 4'h0, 16'h205a, 5'h10, 8'h00, 2'h0, 4'h0},
      '{10'h00e, 2'h2, 3'h0, 4'h0, 16'h225a, 5'h10, 8'h00, 2'h0, 4'h0},
      '{10'h2c3, 2'h2, 3'h0, 4'h9, 16'h926a, 5'h10, 8'h00, 2'h0, 4'h0},
      '{10'h01a, 2'h2, 3'h0, 4'h0, 16'h926a, 5'h10, 8'h29, 2'h0, 4'h0},
      '{10'h00c, 2'h2, 3'h0, 4'h0, 16'h9269, 5'h10, 8'h29, 2'h0, 4'h0},
      '{10'h2df, 2'h2, 3'h0, 4'h4, 16'h4299, 5'h10, 8'h29, 2'h2, 4'h9},
      '{10'h01f, 2'h2, 3'h0, 4'h0, 16'h9299, 5'h10, 8'h29, 2'h0, 4'h0},
      '{10'h029, 2'h2, 3'h0, 4'h0, 16'h9299, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h050, 2'h2, 3'h5, 4'h0, 16'h5299, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h01e, 2'h2, 3'h0, 4'h0, 16'h2299, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h02a, 2'h2, 3'h0, 4'h0, 16'h9299, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h2b1, 2'h2, 3'h0, 4'h0, 16'h9289, 5'h11, 8'h29, 2'h2, 4'h9},
      '{10'h3cf, 2'h2, 3'h0, 4'h0, 16'h92cf, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h013, 2'h2, 3'h0, 4'h0, 16'h92c0, 5'h11, 8'h29, 2'h1, 4'h0},
      '{10'h053, 2'h3, 3'h0, 4'h0, 16'h92c0, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h017, 2'h2, 3'h0, 4'h0, 16'h92cf, 5'h11, 8'h29, 2'h1, 4'h0},
      '{10'h017, 2'h3, 3'h0, 4'h0, 16'h92cf, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h2e0, 2'h2, 3'h0, 4'h7, 16'h72c0, 5'h11, 8'h29, 2'h3, 4'h9},
      '{10'h053, 2'h3, 3'h0, 4'h0, 16'h72c0, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h2f2, 2'h2, 3'h0, 4'h3, 16'h32ef, 5'h11, 8'h29, 2'h3, 4'h7},
      '{10'h017, 2'h3, 3'h0, 4'h0, 16'h32ef, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h2f0, 2'h2, 3'h0, 4'h0, 16'h02ee, 5'h11, 8'h29, 2'h2, 4'h3},
      '{10'h013, 2'h2, 3'h0, 4'h0, 16'h02ef, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h053, 2'h0, 3'h0, 4'h0, 16'h02ef, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h052, 2'h2, 3'h0, 4'h0, 16'he2ef, 5'h11, 8'h29, 2'h0, 4'h0},
      '{10'h051, 2'h2, 3'h0, 4'h0, 16'h12ef, 5'h11, 8'h29, 2'h0, 4'h0}
    };
    repeat (5) @(negedge mclk);
    check_cleared();
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      {instr, exec, skipped} = {rows[i].instr, rows[i].es};
      stack_pointer = rows[i].stk;
      mem_rdata = rows[i].md;
      @(negedge mclk);
      `CHECK({acc, second, row, column}, rows[i].abxy)
      `CHECK({bank, index, pair}, {rows[i].zd, rows[i].e})
      `CHECK({mem_we, skip_next}, rows[i].ws)
      if (rows[i].ws[1])
      begin
        `CHECK(mem_wdata, rows[i].wd)
      end
    end
    // A reset in mid-run clears every register left set by the table.
    {instr, exec, skipped} = {10'h35a, 2'h2};
    rst_n = 1'b0;
    @(negedge mclk);
    check_cleared();
    rst_n = 1'b1;
    @(negedge mclk);
    `CHECK({row, column}, 8'h5a)
    wrap_up();
  end
endmodule
